// file: core/mscsr_bank.sv
// machine status, isa description and interrupt enable csr bank
`timescale 1ns/1ps
`include "mscsr_regs.svh"

// Operation
// RQ1: with wait-timeout set, user-mode wfi traps as illegal at once.
// RQ2: with modify-privilege set, loads and stores use the previous privilege.
// RQ3: previous-privilege keeps only user or machine; mret switches to it.
// RQ4: exception copies global enable to previous; mret copies it back.
// RQ5: software sets global enable inside a handler to allow nested interrupts.
// RQ6: unimplemented status bits always read zero.
// RQ7: isa width field always reads one, meaning 32 bits.
// RQ8: isa bits for compressed, user mode and non-standard read one.
// RQ9: isa full-integer or embedded base bit set by parameter, exactly one.
// RQ10: isa multiply bit set only with full multiply option.
// RQ11: other isa bits read zero and writes never change isa.
// RQ12: without level controller, enable bits 31:16 writable, gate lines 31:16.
// RQ13: without level controller, bit 11 enables external interrupt.
// RQ14: without level controller, bit 7 enables timer interrupt.
// RQ15: without level controller, bit 3 enables software interrupt.
// RQ16: without level controller, other low enable bits read zero.
// RQ17: with level controller, whole enable register reads zero.
// RQ18: illegal value to a legal-only field keeps the previous value.
// RQ19: read-only fields ignore csr writes.
// RQ20: reset gives machine previous-privilege and all status flags clear.
module mscsr_bank #(
    parameter bit BASE_ISA_SELECT_FULL = 1'b1,
    parameter bit MULTIPLY_OPTION = 1'b1,
    parameter bit LEVEL_IRQ_CTRL_OPTION = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic csr_access,
    input wire mscsr_pkg::mscsr_op_t csr_op,
    input wire logic [11:0] csr_addr,
    input wire logic [31:0] csr_wdata,
    input wire logic trap_take,
    input wire logic mret_exec,
    input wire logic wfi_exec,
    input wire logic [31:0] irq_lines,
    output logic [31:0] csr_rdata,
    output logic csr_hit,
    output logic wfi_illegal,
    output mscsr_pkg::mscsr_priv_t priv_mode,
    output mscsr_pkg::mscsr_priv_t data_priv,
    output logic global_irq_enable,
    output logic [31:0] irq_enabled_pending
);
    // --------------------------------------------------------------------
    // stored fields
    // --------------------------------------------------------------------
    logic wait_timeout_bit;
    logic modify_privilege_bit;
    mscsr_pkg::mscsr_priv_t previous_privilege_field;
    logic previous_irq_enable;
    logic [31:0] interrupt_enable_mask;
    logic [31:0] isa_description;
    logic [31:0] machine_status;
    logic [31:0] cur_value;
    logic [31:0] next_value;
    logic wr_status;
    logic wr_irq_en;
    logic next_hit;
    logic [31:0] next_rdata;

    mscsr_isa_rom #(
        .BASE_ISA_SELECT_FULL(BASE_ISA_SELECT_FULL),
        .MULTIPLY_OPTION(MULTIPLY_OPTION)
    ) u_isa_rom (
        .isa_word(isa_description)
    );

    // --------------------------------------------------------------------
    // read view
    // --------------------------------------------------------------------
    always_comb begin
        machine_status = 32'h0000_0000; // [RQ6]
        machine_status[`MSCSR_ST_TW] = wait_timeout_bit;
        machine_status[`MSCSR_ST_MODIFY_PRIVILEGE_BIT] = modify_privilege_bit;
        machine_status[`MSCSR_ST_PP_HI:`MSCSR_ST_PP_LO] = previous_privilege_field;
        machine_status[`MSCSR_ST_PIE] = previous_irq_enable;
        machine_status[`MSCSR_ST_GIE] = global_irq_enable;
    end

    always_comb begin
        next_hit = 1'b1;
        next_rdata = 32'h0000_0000;
        case (csr_addr)
            `MSCSR_ADDR_STATUS: next_rdata = machine_status;
            `MSCSR_ADDR_ISA: next_rdata = isa_description;
            `MSCSR_ADDR_IRQ_EN: next_rdata = interrupt_enable_mask; // [RQ17]
            default: next_hit = 1'b0;
        endcase
    end

    // --------------------------------------------------------------------
    // write value for read-modify-write operations
    // --------------------------------------------------------------------
    always_comb begin
        cur_value = next_rdata;
        case (csr_op)
            mscsr_pkg::MSCSR_OP_WRITE: next_value = csr_wdata;
            mscsr_pkg::MSCSR_OP_SET: next_value = cur_value | csr_wdata;
            mscsr_pkg::MSCSR_OP_CLEAR: next_value = cur_value & ~csr_wdata;
            default: next_value = cur_value;
        endcase
    end

    // a zero op code is a pure read and writes nothing
    assign wr_status = csr_access && (csr_addr == `MSCSR_ADDR_STATUS)
        && (csr_op != 2'h0);
    assign wr_irq_en = csr_access && (csr_addr == `MSCSR_ADDR_IRQ_EN)
        && (csr_op != 2'h0);

    // --------------------------------------------------------------------
    // status register
    // --------------------------------------------------------------------
    // trap and mret win over a software write landing in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            global_irq_enable <= 1'b0; // [RQ20]
            previous_irq_enable <= 1'b0; // [RQ20]
        end else if (trap_take) begin
            previous_irq_enable <= global_irq_enable; // [RQ4]
            global_irq_enable <= 1'b0;
        end else if (mret_exec) begin
            global_irq_enable <= previous_irq_enable; // [RQ4]
            previous_irq_enable <= 1'b1;
        end else if (wr_status) begin
            global_irq_enable <= next_value[`MSCSR_ST_GIE]; // [RQ5]
            previous_irq_enable <= next_value[`MSCSR_ST_PIE];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wait_timeout_bit <= 1'b0; // [RQ20]
            modify_privilege_bit <= 1'b0; // [RQ20]
        end else if (wr_status) begin
            wait_timeout_bit <= next_value[`MSCSR_ST_TW];
            modify_privilege_bit <= next_value[`MSCSR_ST_MODIFY_PRIVILEGE_BIT];
        end
    end

    // legal-only field: user or machine; any other code leaves it unchanged
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            previous_privilege_field <= mscsr_pkg::MSCSR_PRIV_MACHINE; // [RQ20]
        end else if (trap_take) begin
            previous_privilege_field <= priv_mode;
        end else if (mret_exec) begin
            previous_privilege_field <= mscsr_pkg::MSCSR_PRIV_USER;
        end else if (wr_status) begin
            case (next_value[`MSCSR_ST_PP_HI:`MSCSR_ST_PP_LO])
                2'h0: previous_privilege_field <= mscsr_pkg::MSCSR_PRIV_USER; // [RQ3]
                2'h3: previous_privilege_field <= mscsr_pkg::MSCSR_PRIV_MACHINE; // [RQ3]
                default: previous_privilege_field <= previous_privilege_field; // [RQ18]
            endcase
        end
    end

    // --------------------------------------------------------------------
    // privilege tracking
    // --------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            priv_mode <= mscsr_pkg::MSCSR_PRIV_MACHINE;
        end else if (trap_take) begin
            priv_mode <= mscsr_pkg::MSCSR_PRIV_MACHINE;
        end else if (mret_exec) begin
            priv_mode <= previous_privilege_field; // [RQ3]
        end
    end

    // registered copy of the privilege used for data accesses; it trails the
    // stored fields by one cycle, which avoids predicting trap, mret and write
    // outcomes that may land in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_priv <= mscsr_pkg::MSCSR_PRIV_MACHINE;
        end else begin
            data_priv <= modify_privilege_bit ? previous_privilege_field : priv_mode; // [RQ2]
        end
    end

    // --------------------------------------------------------------------
    // wait-for-interrupt check
    // --------------------------------------------------------------------
    // the permitted wait is zero, so the trap is flagged on the next edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wfi_illegal <= 1'b0;
        end else begin
            wfi_illegal <= wfi_exec && wait_timeout_bit
                && (priv_mode == mscsr_pkg::MSCSR_PRIV_USER); // [RQ1]
        end
    end

    // --------------------------------------------------------------------
    // interrupt enable register
    // --------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            interrupt_enable_mask <= `MSCSR_IE_RESET;
        end else if (LEVEL_IRQ_CTRL_OPTION) begin
            interrupt_enable_mask <= 32'h0000_0000; // [RQ17]
        end else if (wr_irq_en) begin
            // masked bits stay zero [RQ16]
            interrupt_enable_mask <= next_value & `MSCSR_IE_WMASK; // [RQ12] [RQ13] [RQ14] [RQ15]
        end
    end

    // per-line gating of the raw interrupt inputs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_enabled_pending <= 32'h0000_0000;
        end else begin
            irq_enabled_pending <= irq_lines & interrupt_enable_mask; // [RQ12] [RQ13] [RQ14] [RQ15]
        end
    end

    // --------------------------------------------------------------------
    // read port
    // --------------------------------------------------------------------
    // isa and fixed zero fields have no write path at all [RQ19]
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            csr_rdata <= 32'h0000_0000;
            csr_hit <= 1'b0;
        end else begin
            csr_rdata <= csr_access ? next_rdata : 32'h0000_0000;
            csr_hit <= csr_access && next_hit;
        end
    end
endmodule // mscsr_bank

// file: inc/mscsr_regs.svh
// register addresses, field positions and reset values of the machine status csr bank
`ifndef MSCSR_REGS_SVH
`define MSCSR_REGS_SVH

`define MSCSR_ADDR_STATUS 12'h0300
`define MSCSR_ADDR_ISA 12'h0301
`define MSCSR_ADDR_IRQ_EN 12'h0304

`define MSCSR_ST_GIE 3
`define MSCSR_ST_PIE 7
`define MSCSR_ST_PP_LO 11
`define MSCSR_ST_PP_HI 12
`define MSCSR_ST_MODIFY_PRIVILEGE_BIT 17
`define MSCSR_ST_TW 21
`define MSCSR_STATUS_RESET 32'h0000_1800

`define MSCSR_ISA_MXL_LO 30
`define MSCSR_ISA_MXL_BASE_ISA_SELECT 2'h1
`define MSCSR_ISA_C 2
`define MSCSR_ISA_E 4
`define MSCSR_ISA_I 8
`define MSCSR_ISA_M 12
`define MSCSR_ISA_U 20
`define MSCSR_ISA_X 23

`define MSCSR_IE_SW 3
`define MSCSR_IE_TIMER 7
`define MSCSR_IE_EXT 11
`define MSCSR_IE_WMASK 32'hFFFF_0888
`define MSCSR_IE_RESET 32'h0000_0000

`endif

// file: inc/mscsr_pkg.sv
// types of the machine status csr bank
package mscsr_pkg;
    typedef enum logic [1:0] {
        MSCSR_PRIV_USER = 2'h0,
        MSCSR_PRIV_MACHINE = 2'h3
    } mscsr_priv_t;

    typedef enum logic [1:0] {
        MSCSR_OP_WRITE = 2'h1,
        MSCSR_OP_SET = 2'h2,
        MSCSR_OP_CLEAR = 2'h3
    } mscsr_op_t;
endpackage

// file: core/mscsr_isa_rom.sv
// fixed isa description word built from the configuration parameters
`timescale 1ns/1ps
`include "mscsr_regs.svh"

module mscsr_isa_rom #(
    parameter bit BASE_ISA_SELECT_FULL = 1'b1,
    parameter bit MULTIPLY_OPTION = 1'b1
) (
    output logic [31:0] isa_word
);
    // no storage at all, so a write can never reach it [RQ11]
    always_comb begin
        isa_word = 32'h0000_0000;
        isa_word[`MSCSR_ISA_MXL_LO +: 2] = `MSCSR_ISA_MXL_BASE_ISA_SELECT; // [RQ7]
        isa_word[`MSCSR_ISA_C] = 1'b1; // [RQ8]
        isa_word[`MSCSR_ISA_U] = 1'b1; // [RQ8]
        isa_word[`MSCSR_ISA_X] = 1'b1; // [RQ8]
        isa_word[`MSCSR_ISA_I] = BASE_ISA_SELECT_FULL; // [RQ9]
        isa_word[`MSCSR_ISA_E] = ~BASE_ISA_SELECT_FULL; // [RQ9]
        isa_word[`MSCSR_ISA_M] = MULTIPLY_OPTION; // [RQ10]
    end
endmodule // mscsr_isa_rom

// file: tb/mscsr_bank_asserts.sv
// port checker of the machine status csr bank
`timescale 1ns/1ps
module mscsr_bank_asserts #(
    parameter bit BASE_ISA_SELECT_FULL = 1'b1,
    parameter bit MULTIPLY_OPTION = 1'b1,
    parameter bit LEVEL_IRQ_CTRL_OPTION = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic csr_access,
    input wire mscsr_pkg::mscsr_op_t csr_op,
    input wire logic [11:0] csr_addr,
    input wire logic [31:0] csr_wdata,
    input wire logic trap_take,
    input wire logic mret_exec,
    input wire logic wfi_exec,
    input wire logic [31:0] irq_lines,
    input wire logic [31:0] csr_rdata,
    input wire logic csr_hit,
    input wire logic wfi_illegal,
    input wire mscsr_pkg::mscsr_priv_t priv_mode,
    input wire mscsr_pkg::mscsr_priv_t data_priv,
    input wire logic global_irq_enable,
    input wire logic [31:0] irq_enabled_pending
);
    localparam logic [31:0] IE_MASK = LEVEL_IRQ_CTRL_OPTION ? 32'h0000_0000 : 32'hFFFF_0888;
    logic st_rd;
    logic isa_rd;
    logic ie_rd;
    assign st_rd = csr_access && csr_addr == 12'h300;
    assign isa_rd = csr_access && csr_addr == 12'h301;
    assign ie_rd = csr_access && csr_addr == 12'h304;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    wfi_user_only_a: assert property (
        wfi_illegal |-> $past(wfi_exec) && $past(priv_mode) == mscsr_pkg::MSCSR_PRIV_USER)
        else $error("wfi fault without user-mode wfi");
    prev_priv_legal_a: assert property (
        st_rd |=> csr_rdata[12:11] != 2'h1 && csr_rdata[12:11] != 2'h2)
        else $error("previous privilege holds an illegal code");
    trap_to_machine_a: assert property (
        trap_take |=> priv_mode == mscsr_pkg::MSCSR_PRIV_MACHINE && !global_irq_enable)
        else $error("trap left privilege or global enable wrong");
    gie_read_a: assert property (
        st_rd |=> csr_rdata[3] == $past(global_irq_enable))
        else $error("status bit 3 disagrees with global enable");
    status_zero_a: assert property (
        st_rd |=> (csr_rdata & ~32'h0022_1888) == 32'h0000_0000)
        else $error("status reserved bit reads one");
    isa_fixed_a: assert property (
        isa_rd |=> csr_rdata[31:30] == 2'h1 && csr_rdata[2] && csr_rdata[20] && csr_rdata[23])
        else $error("isa fixed bits wrong");
    isa_options_a: assert property (
        isa_rd |=> csr_rdata[8] == BASE_ISA_SELECT_FULL && csr_rdata[4] == !BASE_ISA_SELECT_FULL
            && csr_rdata[12] == MULTIPLY_OPTION)
        else $error("isa option bits wrong");
    isa_zero_a: assert property (
        isa_rd |=> (csr_rdata & ~32'h4090_1114) == 32'h0000_0000)
        else $error("isa unnamed bit reads one");
    ie_zero_a: assert property (
        ie_rd |=> (csr_rdata & ~IE_MASK) == 32'h0000_0000)
        else $error("enable hardwired bit reads one");
    pending_masked_a: assert property (
        !$past(rst) |-> (irq_enabled_pending & ~(IE_MASK & $past(irq_lines))) == 32'h0000_0000)
        else $error("pending line not raised or not enabled");
endmodule // mscsr_bank_asserts

bind mscsr_bank mscsr_bank_asserts #(
    .BASE_ISA_SELECT_FULL(BASE_ISA_SELECT_FULL), .MULTIPLY_OPTION(MULTIPLY_OPTION),
    .LEVEL_IRQ_CTRL_OPTION(LEVEL_IRQ_CTRL_OPTION)
) u_asserts (.sys_clk(sys_clk), .rst(rst), .csr_access(csr_access), .csr_op(csr_op),
    .csr_addr(csr_addr), .csr_wdata(csr_wdata), .trap_take(trap_take), .mret_exec(mret_exec),
    .wfi_exec(wfi_exec), .irq_lines(irq_lines), .csr_rdata(csr_rdata), .csr_hit(csr_hit),
    .wfi_illegal(wfi_illegal), .priv_mode(priv_mode), .data_priv(data_priv),
    .global_irq_enable(global_irq_enable), .irq_enabled_pending(irq_enabled_pending));

// file: tb/tb.sv
// self-checking bench of the machine status csr bank
`timescale 1ns/1ps
module tb;
    localparam logic [31:0] ISA_EXP = 32'h4090_1104;
    logic sys_clk, rst, csr_access, trap_take, mret_exec, wfi_exec;
    logic csr_hit, wfi_illegal, global_irq_enable;
    mscsr_pkg::mscsr_op_t csr_op;
    mscsr_pkg::mscsr_priv_t priv_mode, data_priv;
    logic [11:0] csr_addr;
    logic [31:0] csr_wdata, irq_lines, csr_rdata, irq_enabled_pending, st, ie;
    logic [1:0] pr;
    logic [11:0] addrs [4] = '{12'h300, 12'h301, 12'h304, 12'h3FF};
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;

    mscsr_bank DUT (.sys_clk(sys_clk), .rst(rst), .csr_access(csr_access), .csr_op(csr_op),
        .csr_addr(csr_addr), .csr_wdata(csr_wdata), .trap_take(trap_take), .mret_exec(mret_exec),
        .wfi_exec(wfi_exec), .irq_lines(irq_lines), .csr_rdata(csr_rdata), .csr_hit(csr_hit),
        .wfi_illegal(wfi_illegal), .priv_mode(priv_mode), .data_priv(data_priv),
        .global_irq_enable(global_irq_enable), .irq_enabled_pending(irq_enabled_pending));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // checking helpers and expected model
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] app(input logic [1:0] op, input logic [31:0] o,
        input logic [31:0] w);
        return op == 2'h1 ? w : op == 2'h2 ? (o | w) : op == 2'h3 ? (o & ~w) : o;
    endfunction

    // previous-privilege codes 1 and 2 leave the field as it was
    function automatic logic [31:0] nst(input logic [31:0] v, input logic [31:0] o);
        logic [31:0] n;
        n = v & 32'h0022_0888;
        n[12:11] = (v[12:11] == 2'h1 || v[12:11] == 2'h2) ? o[12:11] : v[12:11];
        return n;
    endfunction

    task automatic acc(input logic [1:0] op, input logic [11:0] a, input logic [31:0] w);
        logic [31:0] e;
        e = a == 12'h300 ? st : a == 12'h301 ? ISA_EXP : a == 12'h304 ? ie : 32'h0000_0000;
        csr_op = mscsr_pkg::mscsr_op_t'(op);
        csr_addr = a;
        csr_wdata = w;
        csr_access = 1'b1;
        @(negedge sys_clk);
        csr_access = 1'b0;
        chk(csr_rdata, e);
        chk({31'h0, csr_hit}, {31'h0, a == 12'h300 || a == 12'h301 || a == 12'h304});
        if (a == 12'h300) st = nst(app(op, st, w), st);
        if (a == 12'h304) ie = app(op, ie, w) & 32'hFFFF_0888;
        @(negedge sys_clk);
    endtask

    // k: 0 trap, 1 mret, 2 wfi
    task automatic pulse(input int k);
        trap_take = k == 0;
        mret_exec = k == 1;
        wfi_exec = k == 2;
        @(negedge sys_clk);
        chk({31'h0, wfi_illegal}, {31'h0, k == 2 && st[21] && pr == 2'h0});
        trap_take = 1'b0;
        mret_exec = 1'b0;
        wfi_exec = 1'b0;
        if (k == 0) st = {st[31:13], pr, st[10:8], st[3], st[6:4], 1'b0, st[2:0]};
        if (k == 0) pr = 2'h3;
        if (k == 1) pr = st[12:11];
        if (k == 1) st = {st[31:13], 2'h0, st[10:8], 1'b1, st[6:4], st[7], st[2:0]};
        @(negedge sys_clk);
        chk({30'h0, priv_mode}, {30'h0, pr});
        chk({31'h0, global_irq_enable}, {31'h0, st[3]});
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // generous ceiling: the sequence needs about 126 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            stop_test();
        end
    end

    initial begin
        rst = 1'b1;
        {csr_access, trap_take, mret_exec, wfi_exec} = 4'h0;
        csr_op = mscsr_pkg::MSCSR_OP_WRITE;
        csr_addr = 12'h000;
        csr_wdata = 32'h0000_0000;
        irq_lines = 32'h0000_0000;
        st = 32'h0000_1800;
        ie = 32'h0000_0000;
        pr = 2'h3;
        void'($urandom(67));
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        foreach (addrs[i]) acc(2'h0, addrs[i], 32'h0000_0000);
        acc(2'h1, 12'h300, 32'hFFFF_FFFF);
        acc(2'h1, 12'h300, 32'h0000_1000);
        acc(2'h3, 12'h300, 32'h0000_0800);
        acc(2'h1, 12'h301, 32'h0000_0000);
        repeat (40) acc(2'($urandom_range(3, 1)), addrs[$urandom_range(3, 0)], $urandom);
        acc(2'h2, 12'h304, 32'h0000_0888);
        irq_lines = $urandom;
        repeat (2) @(negedge sys_clk);
        chk(irq_enabled_pending, irq_lines & ie);
        acc(2'h1, 12'h300, 32'h0000_0008);
        pulse(0);
        acc(2'h1, 12'h300, 32'h0020_0080);
        pulse(1);
        pulse(2);
        pulse(0);
        pulse(2);
        acc(2'h1, 12'h300, 32'h0002_0000);
        chk({30'h0, data_priv}, 32'h0000_0000);
        pulse(0);
        chk({30'h0, data_priv}, 32'h0000_0003);
        acc(2'h1, 12'h300, 32'h0000_0000);
        chk({30'h0, data_priv}, 32'h0000_0003);
        acc(2'h0, 12'h300, 32'h0000_0000);
        stop_test();
    end
endmodule // tb
